// ===== core/emps_sideband.v
// Endpoint MSI, function reset and power management sideband logic
`timescale 1ns/100ps
`default_nettype none
`include "emps_regs.vh"
module emps_sideband
#(
    parameter N = `EMPS_MSI_W
)
(
    input wire clk,
    input wire rst,
    input wire [N-1:0] msi_req,
    input wire legacy_req_n,
    input wire intr_disable,
    input wire cfg_msi_enable,
    input wire [`EMPS_MME_W-1:0] cfg_mme,
    input wire [`EMPS_ADDR_W-1:0] cfg_msi_addr,
    input wire [`EMPS_DATA_W-1:0] cfg_msi_data,
    input wire [`EMPS_DC2_W-1:0] cfg_dev_cntl_2,
    input wire cfg_pme_en,
    input wire [`EMPS_PS_W-1:0] cfg_power_state,
    input wire cfg_flr_start,
    input wire flr_rdy_in,
    input wire pme_event,
    input wire tx_ready,
    output wire msi_tx_valid,
    output reg [`EMPS_ADDR_W-1:0] msi_tx_addr,
    output reg [`EMPS_DATA_W-1:0] msi_tx_data,
    output reg leg_assert,
    output reg leg_deassert,
    output reg legacy_status,
    output reg initiate_flr,
    output reg flr_go,
    output reg [`EMPS_DC2_W-1:0] dev_cntl_2_out,
    output reg [`EMPS_MME_W-1:0] vector_count_allowed,
    output reg msi_enable,
    output reg pme_status_bit,
    output reg pme_en,
    output reg [`EMPS_PS_W-1:0] power_state_out
);
    localparam S_IDLE = 2'b01;
    localparam S_SEND = 2'b10;

    reg [N-1:0] msi_prev;
    reg [N-1:0] pend;
    reg [N-1:0] sent;
    reg leg_prev;
    reg [1:0] state;
    reg [1:0] next_state;
    wire any;
    wire [2:0] idx;
    wire [N-1:0] pick;
    wire [N-1:0] rise;
    wire taken;

    // ----------------------------------------
    // Configuration mirrors
    // ----------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dev_cntl_2_out <= 5'h00;
            vector_count_allowed <= 3'h0;
            msi_enable <= 1'b0;
            pme_en <= 1'b0;
            power_state_out <= `EMPS_PS_D0;
            pme_status_bit <= 1'b0;
        end
        else
        begin
            dev_cntl_2_out <= cfg_dev_cntl_2;
            vector_count_allowed <= cfg_mme;
            msi_enable <= cfg_msi_enable;
            pme_en <= cfg_pme_en;
            power_state_out <= cfg_power_state;
            pme_status_bit <= pme_event;
        end
    end

    // ----------------------------------------
    // MSI edge capture
    // ----------------------------------------
    assign rise = msi_req & ~msi_prev;
    assign taken = (state == S_SEND) && tx_ready;

    emps_vec_pick #(.N(N)) u_pick
    (
        .pend(pend),
        .allow_log2(vector_count_allowed),
        .any(any),
        .idx(idx),
        .onehot(pick)
    );

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            msi_prev <= `EMPS_MSI_RST;
            pend <= `EMPS_MSI_RST;
            sent <= `EMPS_MSI_RST;
        end
        else
        begin
            msi_prev <= msi_req;
            // Remember the vector in flight; a lower one may rise meanwhile
            if (state == S_IDLE && any && msi_enable)
                sent <= pick;
            // New edge wins over the clear of the same vector
            if (!msi_enable)
                pend <= {N{1'b0}};
            else if (taken)
                pend <= (pend & ~sent) | rise;
            else
                pend <= pend | rise;
        end
    end

    // ----------------------------------------
    // MSI write issue
    // ----------------------------------------
    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:
                if (any && msi_enable)
                    next_state = S_SEND;
            S_SEND:
                if (tx_ready)
                    next_state = S_IDLE;
            default:
                next_state = S_IDLE;
        endcase
    end

    assign msi_tx_valid = (state == S_SEND);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            msi_tx_addr <= 64'h0000000000000000;
            msi_tx_data <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            if (state == S_IDLE && any && msi_enable)
            begin
                msi_tx_addr <= cfg_msi_addr;
                // Low data bits carry the vector number
                msi_tx_data <= cfg_msi_data | {13'h0000, idx};
            end
        end
    end

    // ----------------------------------------
    // Legacy interrupt messages
    // ----------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            leg_prev <= `EMPS_LEG_RST;
            leg_assert <= 1'b0;
            leg_deassert <= 1'b0;
            legacy_status <= 1'b0;
        end
        else
        begin
            leg_prev <= legacy_req_n;
            leg_assert <= 1'b0;
            leg_deassert <= 1'b0;
            if (!msi_enable)
            begin
                if (leg_prev && !legacy_req_n)
                begin
                    legacy_status <= 1'b1;
                    leg_assert <= ~intr_disable;
                end
                else if (!leg_prev && legacy_req_n)
                begin
                    legacy_status <= 1'b0;
                    leg_deassert <= ~intr_disable;
                end
            end
        end
    end

    // ----------------------------------------
    // Function level reset handshake
    // ----------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            initiate_flr <= 1'b0;
            flr_go <= 1'b0;
        end
        else
        begin
            flr_go <= 1'b0;
            if (cfg_flr_start)
                initiate_flr <= 1'b1;
            else if (initiate_flr && flr_rdy_in)
            begin
                initiate_flr <= 1'b0;
                flr_go <= 1'b1;
            end
        end
    end
endmodule // emps_sideband
`default_nettype wire

// ===== core/emps_vec_pick.v
// Priority picker for pending MSI vectors
`timescale 1ns/100ps
`default_nettype none
`include "emps_regs.vh"
module emps_vec_pick
#(
    parameter N = 8
)
(
    input wire [N-1:0] pend,
    input wire [2:0] allow_log2,
    output reg any,
    output reg [2:0] idx,
    output reg [N-1:0] onehot
);
    integer i;
    // ----------------------------------------
    // Lowest pending vector wins
    // ----------------------------------------
    always @*
    begin
        any = 1'b0;
        idx = 3'h0;
        onehot = {N{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1)
        begin
            if (pend[i])
            begin
                any = 1'b1;
                idx = i[2:0];
                onehot = {{(N-1){1'b0}}, 1'b1} << i;
            end
        end
        // Vectors past the allowed count wrap by masking the low bits
        if (allow_log2 < 3'h3)
        begin
            idx = idx & ((3'h1 << allow_log2) - 3'h1);
        end
    end
endmodule // emps_vec_pick
`default_nettype wire

// ===== pkg/emps_regs.vh
// Constants for the endpoint MSI / power management sideband block
`ifndef EMPS_REGS_VH
`define EMPS_REGS_VH
// ----------------------------------------
// Field widths and reset values
// ----------------------------------------
`define EMPS_MSI_W 8
`define EMPS_DC2_W 5
`define EMPS_MME_W 3
`define EMPS_PS_W 2
`define EMPS_ADDR_W 64
`define EMPS_DATA_W 16
`define EMPS_VEC_W 3
`define EMPS_PS_D0 2'h0
`define EMPS_PS_D1 2'h1
`define EMPS_PS_D2 2'h2
`define EMPS_PS_D3 2'h3
`define EMPS_MSI_RST 8'h00
`define EMPS_LEG_RST 1'h1
`endif

// ===== verif/emps_far_model.sv
// Far side model: TLP path sink and user reset handshake
`timescale 1ns/100ps
`default_nettype none
module emps_far_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic initiate_flr,
    output logic tx_ready,
    output logic flr_rdy_in
);
    logic [2:0] cnt = 3'h0;
    always @(posedge clk)
        cnt <= cnt + 3'h1;
    // Stalling path takes one write in eight cycles
    assign tx_ready = !stall || cnt == 3'h3;
    // Ready only after the request is seen
    assign flr_rdy_in = initiate_flr && cnt == 3'h5;
endmodule // emps_far_model
`default_nettype wire

// ===== verif/emps_sideband_props.sv
// Assertion checker for the endpoint sideband block
`timescale 1ns/100ps
`default_nettype none
module emps_sideband_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic legacy_req_n,
    input wire logic intr_disable,
    input wire logic [2:0] cfg_mme,
    input wire logic [4:0] cfg_dev_cntl_2,
    input wire logic [1:0] cfg_power_state,
    input wire logic cfg_flr_start,
    input wire logic flr_rdy_in,
    input wire logic leg_assert,
    input wire logic leg_deassert,
    input wire logic initiate_flr,
    input wire logic [4:0] dev_cntl_2_out,
    input wire logic [2:0] vector_count_allowed,
    input wire logic msi_enable,
    input wire logic [1:0] power_state_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_dc2_copy:
    assert property (1 |=> dev_cntl_2_out == $past(cfg_dev_cntl_2)) else $error("dc2");
    a_mme_copy:
    assert property (##1 vector_count_allowed == $past(cfg_mme)) else $error("mme");
    a_state_copy:
    assert property ($stable(cfg_power_state) [*2] |->
        power_state_out == cfg_power_state) else $error("state");
    a_leg_quiet:
    assert property (leg_assert || leg_deassert |-> !$past(msi_enable))
        else $error("legacy while msi");
    a_leg_fall:
    assert property ($fell(legacy_req_n) && !msi_enable && !intr_disable
        |=> leg_assert) else $error("assert msg");
    a_leg_rise:
    assert property ($rose(legacy_req_n) && !msi_enable && !intr_disable
        |=> leg_deassert) else $error("deassert msg");
    a_flr_start:
    assert property (cfg_flr_start && !initiate_flr |-> ##1 initiate_flr)
        else $error("flr start");
    a_flr_hold:
    assert property (initiate_flr && !flr_rdy_in |=> initiate_flr)
        else $error("flr hold");
    c_las: cover property (leg_assert);
    c_lde: cover property (leg_deassert);
    c_flr: cover property (initiate_flr && flr_rdy_in);
endmodule // emps_sideband_props
bind emps_sideband emps_sideband_props i_props (.*);
`default_nettype wire

// ===== verif/test_emps_sideband.sv
// Bench for the endpoint sideband block
`timescale 1ns/100ps
`default_nettype none
module test_emps_sideband;
    logic clk = 1'h0, rst = 1'h1, legacy_req_n = 1'h1, intr_disable = 1'h0;
    logic cfg_msi_enable = 1'h0, cfg_pme_en = 1'h0, cfg_flr_start = 1'h0;
    logic pme_event = 1'h0, stall = 1'h0, tx_ready, flr_rdy_in, msi_tx_valid;
    logic leg_assert, leg_deassert, legacy_status, initiate_flr, flr_go;
    logic msi_enable, pme_status_bit, pme_en;
    logic [7:0] msi_req = 8'h00;
    logic [2:0] cfg_mme = 3'h0, vector_count_allowed;
    logic [63:0] cfg_msi_addr = 64'hFEE0_1000, msi_tx_addr;
    logic [15:0] cfg_msi_data = 16'h4A00, msi_tx_data;
    logic [4:0] cfg_dev_cntl_2 = 5'h00, dev_cntl_2_out;
    logic [1:0] cfg_power_state = 2'h0, power_state_out;
    int bad_count = 0, total_checks = 0, i;
    emps_sideband i_emps_sideband (.*);
    emps_far_model i_emps_far_model (.*);
    initial
        forever #25 clk = ~clk;
    initial
    begin
        repeat (2000) @(posedge clk);
        bad_count++;
        finish_test;
    end
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string s, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task got(input logic [15:0] v);
        repeat (30) if ((msi_tx_valid & tx_ready) !== 1'h1) tick(1);
        chk("valid", 1, msi_tx_valid & tx_ready);
        chk("data", cfg_msi_data | v, msi_tx_data);
        tick(1);
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        tick(8);
        rst = 1'h0;
        tick(1);
        chk("ps0", 0, power_state_out);
        for (i = 0; i < 4; i++)
        begin
            cfg_dev_cntl_2 = 5'h13 + i[4:0];
            cfg_mme = i[2:0];
            cfg_power_state = i[1:0];
            cfg_pme_en = i[0];
            pme_event = !i[0];
            tick(2);
            chk("dc2", cfg_dev_cntl_2, dev_cntl_2_out);
            chk("mme", cfg_mme, vector_count_allowed);
            chk("pst", pme_event, pme_status_bit);
            chk("pen", cfg_pme_en, pme_en);
            chk("ps", i, power_state_out);
        end
        for (i = 0; i < 2; i++)
        begin
            cfg_msi_enable = i[0];
            tick(2);
            chk("men", i[0], msi_enable);
            legacy_req_n = 1'h0;
            tick(1);
            chk("las", !i[0], leg_assert);
            chk("lst", !i[0], legacy_status);
            tick(2);
            legacy_req_n = 1'h1;
            tick(1);
            chk("lde", !i[0], leg_deassert);
            chk("lst0", 0, legacy_status);
        end
        for (i = 0; i < 8; i++)
        begin
            stall = i[0];
            msi_req = 8'h01 << i;
            tick(2);
            chk("addr", cfg_msi_addr, msi_tx_addr);
            got(i);
        end
        // Two rises at once: lowest vector leaves first
        msi_req = 8'h03;
        got(0);
        got(1);
        // Two vectors allowed: vector 3 wraps to index 1
        cfg_mme = 3'h1;
        msi_req = 8'h08;
        got(16'h0001);
        cfg_flr_start = 1'h1;
        tick(1);
        cfg_flr_start = 1'h0;
        chk("flr", 1, initiate_flr);
        repeat (20) if (initiate_flr === 1'h1) tick(1);
        chk("go", 1, flr_go);
        chk("flr0", 0, initiate_flr);
        finish_test;
    end
endmodule // test_emps_sideband
`default_nettype wire
